//--- jril_bridge_model.sv
// model of the user tap bridge feeding the loader
`timescale 1ns/100ps
module jril_bridge_model (
	output logic tck,
	output logic tdi,
	output logic [7:0] cmd,
	output logic shift_en,
	output logic update
);
	initial begin
		tck = 0;
		tdi = 0;
		cmd = 8'h00;
		shift_en = 0;
		update = 0;
	end
	// free clock pulses, no shifting
	task automatic pulse(input int n);
		repeat (n) begin
			#24 tck = 1;
			#24 tck = 0;
		end
	endtask
	// one frame, lsb first, clock only inside it
	task automatic send(input logic [7:0] c, input logic [8:0] v, input logic upd);
		cmd = c;
		shift_en = 1;
		for (int i = 0; i < 9; i++) begin
			tdi = v[i];
			pulse(1);
		end
		shift_en = 0;
		tdi = ~v[8]; // released line shows no stale bit
		if (upd) begin
			update = 1;
			pulse(1);
			update = 0;
		end
		#48; // clock stands still between frames
	endtask
endmodule // jril_bridge_model

//--- jril_loader.sv
// module: jtag ram init loader, tap side shifting and ram side writing
`timescale 1ns/100ps
module jril_loader
	import jril_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic bridge_data_reg_clock,
	input wire logic bridge_serial_data_out,
	input wire logic [7:0] bridge_cmd,
	input wire logic bridge_shift_en,
	input wire logic bridge_update,
	input wire logic user_wr_valid,
	input wire logic [DATA_W-1:0] user_wr_data,
	input wire logic [ADDR_W-1:0] user_wr_addr,
	input wire logic [NUM_BLK-1:0] user_wr_sel,
	output logic user_wr_ready,
	input wire logic jtag_mode,
	output logic ram_wclk,
	output logic [NUM_BLK-1:0] ram_blk_sel,
	output logic [ADDR_W-1:0] ram_waddr,
	output logic [DATA_W-1:0] ram_wdata,
	output logic ram_wen,
	output logic [ADDR_W-1:0] words_written
);
	// ----------------------------------------
	// tap domain: shifting and word capture
	// ----------------------------------------
	logic [DATA_W-1:0] data_shift;
	logic [ADDR_W-1:0] addr_shift;
	logic [$clog2(DATA_W+1)-1:0] bit_cnt;
	logic [DATA_W-1:0] tap_word;
	logic [ADDR_W-1:0] tap_addr;
	logic word_tgl;
	logic addr_tgl;
	wire cmd_is_data = (bridge_cmd == CMD_DATA);
	wire cmd_is_addr = (bridge_cmd == CMD_ADDR);
	wire word_full = (bit_cnt == ($clog2(DATA_W+1))'(DATA_W - 1));
	// lsb-first serial entry: each new bit lands on top and walks down
	function automatic logic [DATA_W-1:0] shift_in(input logic [DATA_W-1:0] cur, input logic bit_in);
		shift_in = {bit_in, cur[DATA_W-1:1]};
	endfunction
	wire [DATA_W-1:0] next_data_shift = shift_in(data_shift, bridge_serial_data_out);
	wire [ADDR_W-1:0] next_addr_shift = shift_in(addr_shift, bridge_serial_data_out);

	// serial in, lsb first; word stored once full
	always_ff @(posedge bridge_data_reg_clock or negedge rst_n) begin
		if (!rst_n) begin
			data_shift <= '0;
			bit_cnt <= '0;
			tap_word <= '0;
			word_tgl <= 1'b0;
		end else if (bridge_shift_en && cmd_is_data) begin
			data_shift <= next_data_shift;
			bit_cnt <= word_full ? '0 : bit_cnt + 1'b1;
			if (word_full) begin
				tap_word <= next_data_shift;
				word_tgl <= ~word_tgl;
			end
		end
	end

	// second shift register for tap-loaded address
	always_ff @(posedge bridge_data_reg_clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_shift <= '0;
			tap_addr <= ADDR_RST;
			addr_tgl <= 1'b0;
		end else if (bridge_shift_en && cmd_is_addr) begin
			addr_shift <= next_addr_shift;
		end else if (bridge_update && cmd_is_addr) begin
			tap_addr <= addr_shift;
			addr_tgl <= ~addr_tgl;
		end
	end

	// ----------------------------------------
	// tap domain checks
	// ----------------------------------------
	// a full word always flips the toggle
	AST_WORD_TGL: assert property (@(posedge bridge_data_reg_clock) disable iff (!rst_n)
		(bridge_shift_en && cmd_is_data && word_full) |=> word_tgl != $past(word_tgl))
		else $error("full word not handed over");
	// stored word is the freshly completed shift value
	AST_TAP_WORD: assert property (@(posedge bridge_data_reg_clock) disable iff (!rst_n)
		(bridge_shift_en && cmd_is_data && word_full) |=> tap_word == $past(next_data_shift))
		else $error("stored word differs from shifted bits");
	// bit counter restarts after the last bit
	AST_BIT_RESTART: assert property (@(posedge bridge_data_reg_clock) disable iff (!rst_n)
		(bridge_shift_en && cmd_is_data && word_full) |=> bit_cnt == '0)
		else $error("bit counter did not restart");
	// no shifting without the data command
	AST_SHIFT_IDLE: assert property (@(posedge bridge_data_reg_clock) disable iff (!rst_n)
		!(bridge_shift_en && cmd_is_data) |=> $stable(data_shift))
		else $error("data shifted outside a data frame");
	// update copies the address shift register
	AST_ADDR_CAPTURE: assert property (@(posedge bridge_data_reg_clock) disable iff (!rst_n)
		(bridge_update && cmd_is_addr && !bridge_shift_en) |=> tap_addr == $past(addr_shift))
		else $error("tap address not captured");

	// ----------------------------------------
	// crossing into core clock
	// ----------------------------------------
	logic [2:0] word_sync;
	logic [2:0] addr_sync;
	logic [1:0] mode_sync;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_sync <= '0;
			addr_sync <= '0;
			mode_sync <= '0;
		end else begin
			word_sync <= {word_sync[1:0], word_tgl};
			addr_sync <= {addr_sync[1:0], addr_tgl};
			mode_sync <= {mode_sync[0], jtag_mode};
		end
	end
	wire word_evt = word_sync[2] ^ word_sync[1];
	wire addr_evt = addr_sync[2] ^ addr_sync[1];
	wire jtag_sel = mode_sync[1];

	// ----------------------------------------
	// two-entry buffer between capture and write
	// ----------------------------------------
	jril_wr_t buf_mem [BUF_DEPTH];
	logic buf_wp;
	logic buf_rp;
	logic [1:0] buf_cnt;
	logic [ADDR_W-1:0] addr_cnt;
	logic [NUM_BLK-1:0] ring;
	jril_wr_t in_ent;
	jril_wr_t user_ent;
	wire buf_full = (buf_cnt == 2'(BUF_DEPTH));
	wire buf_empty = (buf_cnt == 2'h0);
	// tap words: address counter, ring selected
	assign in_ent = '{data: tap_word, addr: addr_cnt, sel: ring};
	assign user_ent = '{data: user_wr_data, addr: user_wr_addr, sel: user_wr_sel};
	wire in_valid = jtag_sel ? word_evt : user_wr_valid;
	wire in_ready = !buf_full;
	assign user_wr_ready = !jtag_sel && in_ready;
	wire push = in_valid && in_ready;
	wire pop = !buf_empty; // write stage always drains
	jril_wr_t push_ent;
	assign push_ent = jtag_sel ? in_ent : user_ent;

	// buffer pointers and storage
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_wp <= 1'b0;
			buf_rp <= 1'b0;
			buf_cnt <= '0;
		end else begin
			buf_wp <= buf_wp ^ push;
			buf_rp <= buf_rp ^ pop;
			buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
		end
	end
	always_ff @(posedge core_clk) begin
		if (push)
			buf_mem[buf_wp] <= push_ent;
	end

	// ----------------------------------------
	// buffer checks
	// ----------------------------------------
	// an accepted user write lands in the buffer
	AST_USER_TAKE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(user_wr_valid && user_wr_ready) |=> !buf_empty)
		else $error("accepted user write not buffered");
	// no tap word is lost at the buffer
	AST_EVT_PUSH: assert property (@(posedge core_clk) disable iff (!rst_n)
		(word_evt && jtag_sel) |-> push)
		else $error("tap word dropped at buffer");
	// user path closed while tap data owns the rams
	AST_USER_BLOCK: assert property (@(posedge core_clk) disable iff (!rst_n)
		jtag_sel |-> !user_wr_ready)
		else $error("user path open in tap mode");

	// ----------------------------------------
	// address counter and ring chip select
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_cnt <= ADDR_RST;
			ring <= SEL_RST;
		end else if (addr_evt) begin
			addr_cnt <= tap_addr; // settled before its toggle clears both flops
		end else if (push && jtag_sel) begin
			addr_cnt <= addr_cnt + 1'b1;
			if (addr_cnt == ADDR_LAST)
				ring <= {ring[NUM_BLK-2:0], ring[NUM_BLK-1]};
		end
	end

	// ----------------------------------------
	// address checks
	// ----------------------------------------
	// tap address loads the counter
	AST_ADDR_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
		addr_evt |=> addr_cnt == $past(tap_addr))
		else $error("tap address not loaded");
	// counter holds when nothing is captured
	AST_ADDR_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!addr_evt && !(push && jtag_sel)) |=> $stable(addr_cnt))
		else $error("address counter moved without a word");
	// wrap at the last address moves to the next block
	AST_RING_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		(push && jtag_sel && !addr_evt && addr_cnt == ADDR_LAST) |=>
			ring == {$past(ring[NUM_BLK-2:0]), $past(ring[NUM_BLK-1])})
		else $error("ring select did not step on wrap");

	// ----------------------------------------
	// write stage, registered outputs and inverted write clock
	// ----------------------------------------
	jril_wr_t out_ent;
	assign out_ent = buf_mem[buf_rp];
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ram_wdata <= '0;
			ram_waddr <= ADDR_RST;
			ram_blk_sel <= '0;
			ram_wen <= 1'b0;
			words_written <= '0;
		end else begin
			ram_wen <= pop;
			ram_blk_sel <= pop ? out_ent.sel : '0;
			if (pop) begin
				ram_wdata <= out_ent.data;
				ram_waddr <= out_ent.addr;
				words_written <= words_written + 1'b1;
			end
		end
	end
	// ram samples on rising edge of the inverted core clock
	assign ram_wclk = ~core_clk;

	// ----------------------------------------
	// write stage checks
	// ----------------------------------------
	// every drained entry becomes one counted write
	AST_COUNT_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		pop |=> ram_wen && words_written == $past(words_written) + 1'b1)
		else $error("drained entry not written once");
	// chip select follows the drained entry
	AST_SEL_MATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
		pop |=> ram_blk_sel == $past(out_ent.sel))
		else $error("chip select differs from entry");
	// address follows the drained entry
	AST_ADDR_PIPE: assert property (@(posedge core_clk) disable iff (!rst_n)
		pop |=> ram_waddr == $past(out_ent.addr))
		else $error("write address differs from entry");
	// data and address stand between writes
	AST_WDATA_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		!pop |=> $stable(ram_wdata) && $stable(ram_waddr))
		else $error("write data or address moved while idle");

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_ONE_SEL: assert property (@(posedge core_clk) disable iff (!rst_n)
		ram_wen |-> $onehot(ram_blk_sel))
		else $error("chip select not one-hot during write");
	AST_NO_SEL_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ram_wen |-> ram_blk_sel == '0)
		else $error("chip select active without write");
	AST_EVT_WRITES: assert property (@(posedge core_clk) disable iff (!rst_n)
		(push && buf_empty) |-> ##1 pop ##1 ram_wen)
		else $error("captured word not written");
	AST_ADDR_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		(push && jtag_sel && !addr_evt) |=> addr_cnt == $past(addr_cnt) + 1'b1)
		else $error("address counter did not advance");
	AST_NO_OVERFLOW: assert property (@(posedge core_clk) disable iff (!rst_n)
		buf_cnt <= 2'(BUF_DEPTH))
		else $error("buffer count exceeded depth");
	AST_DATA_PIPE: assert property (@(posedge core_clk) disable iff (!rst_n)
		pop |=> ram_wdata == $past(out_ent.data))
		else $error("write data not aligned");
	AST_RING_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		$onehot(ring))
		else $error("ring counter lost its token");
	AST_BIT_CNT: assert property (@(posedge bridge_data_reg_clock) disable iff (!rst_n)
		bit_cnt < ($clog2(DATA_W+1))'(DATA_W))
		else $error("bit counter out of range");
	AST_WORD_FULL: assert property (@(posedge bridge_data_reg_clock) disable iff (!rst_n)
		(bridge_shift_en && cmd_is_data && !word_full) |=> $stable(word_tgl))
		else $error("partial word handed over");
	COV_JTAG_WRITE: cover property (@(posedge core_clk) disable iff (!rst_n) jtag_sel && ram_wen);
	COV_USER_WRITE: cover property (@(posedge core_clk) disable iff (!rst_n) !jtag_sel && ram_wen);
	COV_BUF_FULL: cover property (@(posedge core_clk) disable iff (!rst_n) buf_full);
	COV_ADDR_LOAD: cover property (@(posedge core_clk) disable iff (!rst_n) addr_evt);
	COV_RING_STEP: cover property (@(posedge core_clk) disable iff (!rst_n) push && jtag_sel && addr_cnt == ADDR_LAST);
endmodule // jril_loader

//--- jril_pkg.sv
// package: constants and carrier types for the jtag ram init loader
package jril_pkg;
	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int DATA_W = 9;
	localparam int ADDR_W = 9;
	localparam int NUM_BLK = 4;
	localparam int BUF_DEPTH = 2;
	// ----------------------------------------
	// bridge commands (user instruction codes)
	// ----------------------------------------
	localparam logic [7:0] CMD_DATA = 8'h10;
	localparam logic [7:0] CMD_ADDR = 8'h11;
	// ----------------------------------------
	// reset values and last address
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
	localparam logic [NUM_BLK-1:0] SEL_RST = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 9'h1ff;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [ADDR_W-1:0] addr;
		logic [NUM_BLK-1:0] sel;
	} jril_wr_t;
	typedef enum logic [0:0] {
		JRIL_IDLE = 1'b0,
		JRIL_WRITE = 1'b1
	} jril_state_t;
endpackage

//--- tb_top.sv
// testbench: bridge frames and user writes into the loader
`timescale 1ns/100ps
module tb_top;
	import jril_pkg::*;
	logic core_clk = 0, rst_n = 0, jtag_mode = 0, user_wr_valid = 0;
	logic [8:0] user_wr_data = '0, user_wr_addr = '0, ram_waddr, ram_wdata, words_written;
	logic [3:0] user_wr_sel = '0, ram_blk_sel;
	logic tck, tdi, shift_en, update, user_wr_ready, ram_wclk, ram_wen;
	logic [7:0] cmd;
	int error_cnt = 0, total_checks = 0, cycles = 0;
	jril_wr_t wq[$];
	always #12.5 core_clk = ~core_clk;
	jril_bridge_model bfm (.tck(tck), .tdi(tdi), .cmd(cmd), .shift_en(shift_en), .update(update));
	jril_loader dut (.core_clk(core_clk), .rst_n(rst_n), .bridge_data_reg_clock(tck),
		.bridge_serial_data_out(tdi), .bridge_cmd(cmd), .bridge_shift_en(shift_en),
		.bridge_update(update), .user_wr_valid(user_wr_valid), .user_wr_data(user_wr_data),
		.user_wr_addr(user_wr_addr), .user_wr_sel(user_wr_sel), .user_wr_ready(user_wr_ready),
		.jtag_mode(jtag_mode), .ram_wclk(ram_wclk), .ram_blk_sel(ram_blk_sel), .ram_waddr(ram_waddr),
		.ram_wdata(ram_wdata), .ram_wen(ram_wen), .words_written(words_written));
	// ----------------------------------------
	// write monitor, timeout and helpers
	// ----------------------------------------
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (ram_wen === 1'b1)
			wq.push_back({ram_wdata, ram_waddr, ram_blk_sel});
		if (cycles == 20000) begin
			error_cnt++;
			results();
		end
	end
	task automatic chk(string what, logic [21:0] exp, logic [21:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic exp_wr(logic [8:0] d, logic [8:0] a, logic [3:0] s);
		for (int i = 0; i < 12 && wq.size() == 0; i++)
			@(negedge core_clk);
		if (wq.size() == 0)
			chk("write seen", 22'h1, 22'h0);
		else
			chk("write", {d, a, s}, wq.pop_front());
	endtask
	task automatic user_wr(logic [8:0] d, logic [8:0] a, logic [3:0] s);
		user_wr_valid = 1;
		user_wr_data = d;
		user_wr_addr = a;
		user_wr_sel = s;
		while (user_wr_ready !== 1'b1)
			@(negedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		bfm.pulse(2);
		chk("reset outputs", 22'h0, {ram_wdata, ram_waddr, ram_blk_sel});
		chk("reset write enable", 22'h0, {21'h0, ram_wen});
		chk("reset count", 22'h0, {13'h0, words_written});
		chk("write clock", {21'h0, ~core_clk}, {21'h0, ram_wclk});
	endtask
	task automatic t_tap();
		jtag_mode = 1;
		repeat (4) @(negedge core_clk);
		chk("user ready in tap mode", 22'h0, {21'h0, user_wr_ready});
		bfm.send(CMD_DATA, 9'h1a5, 0);
		bfm.send(CMD_DATA, 9'h05a, 0);
		exp_wr(9'h1a5, 9'h000, 4'h1);
		exp_wr(9'h05a, 9'h001, 4'h1);
		bfm.send(8'h00, 9'h1ff, 0);
		repeat (12) @(negedge core_clk);
		chk("stray writes", 22'h0, 22'(wq.size()));
		chk("word count", 22'h2, {13'h0, words_written});
	endtask
	task automatic t_addr();
		bfm.send(CMD_ADDR, ADDR_LAST, 1);
		repeat (8) @(negedge core_clk);
		bfm.send(CMD_DATA, 9'h0ff, 0);
		bfm.send(CMD_DATA, 9'h100, 0);
		exp_wr(9'h0ff, ADDR_LAST, 4'h1);
		exp_wr(9'h100, 9'h000, 4'h2);
	endtask
	task automatic t_user();
		jtag_mode = 0;
		repeat (4) @(negedge core_clk);
		user_wr(9'h155, 9'h0aa, 4'h8);
		user_wr(9'h0aa, 9'h0ab, 4'h4);
		user_wr_valid = 0;
		exp_wr(9'h155, 9'h0aa, 4'h8);
		exp_wr(9'h0aa, 9'h0ab, 4'h4);
		chk("word count", 22'h6, {13'h0, words_written});
	endtask
	initial begin
		repeat (10) @(negedge core_clk);
		t_reset();
		@(negedge core_clk);
		rst_n = 1;
		@(negedge core_clk);
		t_tap();
		t_addr();
		t_user();
		results();
	end
endmodule // tb_top
